// File: rtl/nvr_pkg.sv
package nvr_pkg;
  // ==========================================================
  // Addressing and storage layout
  localparam logic [5:0] DEV_ADDR_HI = 6'h3a;
  localparam int NREG = 11;
  localparam int IDX_W = 4;
  localparam logic [7:0] RT_FREE_MAX = 8'h02;
  // Factory content, register 0 in the low byte
  localparam logic [87:0] NVM_DEFAULT = {8'h7f, 8'h40, 8'h05, 8'h05, 8'h05, 8'h15,
                                         8'h15, 8'h15, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] RT_RESET = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_US = 200;
  localparam int POR_CYCLES = (POR_US * (CLK_HZ / 1_000_000) > 0) ?
                              POR_US * (CLK_HZ / 1_000_000) : 1;
  localparam int NVM_GAP_MS = 100;
  localparam int NVM_GAP_CYCLES = NVM_GAP_MS * (CLK_HZ / 1000);
  localparam int SCL_MAX_HZ = 400_000;
  localparam int SCL_Q_CYCLES = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  // ==========================================================
  // State encodings
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_ADDR = 5'h02,
    DS_SUB = 5'h04,
    DS_WR = 5'h08,
    DS_RD = 5'h10
  } nvr_dst_t;

  typedef enum logic [4:0] {
    HS_WAIT = 5'h01,
    HS_IDLE = 5'h02,
    HS_START = 5'h04,
    HS_BYTE = 5'h08,
    HS_STOP = 5'h10
  } nvr_hst_t;
endpackage : nvr_pkg

// File: rtl/nvr_if.sv
`timescale 1ns/10ps
interface nvr_if;
  // Host drive of the clock line (pulls low when enabled)
  logic scl_o;
  logic scl_oe;
  // Data line drivers of each end
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  // Storage select, low routes to nonvolatile storage
  logic storage_select_n;
  // Resolved wires with pull-up
  wire logic scl;
  wire logic sda;

  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport dev (input scl, input sda, input storage_select_n, output sda_d_o, output sda_d_oe);
  modport host (input sda, output scl_o, output scl_oe, output sda_h_o, output sda_h_oe,
                output storage_select_n);
endinterface : nvr_if

// File: rtl/nvr_sync.sv
`timescale 1ns/10ps
module nvr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;

  // ==========================================================
  // Two-stage synchroniser, idles high like the bus
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s1_q <= '1;
      q <= '1;
    end
    else
    begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : nvr_sync

// File: rtl/nvr_dev.sv
// Functional notes
// - Select low on write stores to storage
// - Host may write right after select low
// - Host spaces storage writes by 100 ms
// - Storage write also copied to run-time register
// - Select high writes go to run-time registers
// - Storage writes ignored below 8 V supply
// - Offsets above 02h written only enable low
// - Select high reads return run-time contents
// - Select low reads return storage contents
// - Permanent low select: read only when disabled
// - Avoid holding select permanently low
// - Power-on load from storage, bus idle
// - Bus clock up to 400 kHz
// - Start condition begins a transaction
// - Match address, acknowledge one clock
// - Sub-address byte selects the register
// - Stop condition ends a transaction
// - Address 111010 plus strap pin level
// - Offsets 00h-02h hold voltage settings
`timescale 1ns/10ps
module nvr_dev (
  // Bus side
  nvr_if.dev bus,
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Board pins
  input wire logic address_strap_pin,
  input wire logic reg_enable,
  input wire logic supply_ge_8v,
  // Run-time register contents and load status
  output logic [nvr_pkg::NREG*8-1:0] rt_regs,
  output logic loading
);
  localparam int NR = nvr_pkg::NREG;
  logic [5:0] syn;
  logic scl_s, sda_s, sel_n_s, en_s, vin_s, strap_s;
  logic scl_p_q, sda_p_q, scl_rise, scl_fall, start_det, stop_det;
  logic [nvr_pkg::POR_W-1:0] por_cnt_q;
  logic loading_q, load_done;
  logic [7:0] nvm_q [NR];
  logic [7:0] rt_q [NR];
  nvr_pkg::nvr_dst_t state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shreg_q, tx_q, ptr_q, rd_val;
  logic rw_q, mnack_q, sda_oe_q, in_range, wr_fire;
  logic [nvr_pkg::IDX_W-1:0] idx;

  // ==========================================================
  // Pin synchronisation and bus event detection
  nvr_sync #(
    .W(6)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({bus.scl, bus.sda, bus.storage_select_n, reg_enable, supply_ge_8v, address_strap_pin}),
    .q(syn)
  );

  assign {scl_s, sda_s, sel_n_s, en_s, vin_s, strap_s} = syn;

  // Previous line levels
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Edges and bus conditions
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ==========================================================
  // Power-on load timer, bus ignored meanwhile
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      por_cnt_q <= '0;
      loading_q <= 1'b1;
    end
    else if (loading_q)
    begin
      if (por_cnt_q == nvr_pkg::POR_W'(nvr_pkg::POR_CYCLES - 1))
        loading_q <= 1'b0;
      else
        por_cnt_q <= por_cnt_q + 1'b1;
    end
  end
  assign load_done = loading_q && (por_cnt_q == nvr_pkg::POR_W'(nvr_pkg::POR_CYCLES - 1));

  // ==========================================================
  // Storage and run-time arrays
  assign in_range = ptr_q < 8'(NR);
  assign idx = ptr_q[nvr_pkg::IDX_W-1:0];
  assign wr_fire = scl_fall && (bitcnt_q == 4'h7) && (state_q == nvr_pkg::DS_WR);
  // Write routing by select, supply and enable
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NR; i++)
      begin
        nvm_q[i] <= nvr_pkg::NVM_DEFAULT[i*8 +: 8];
        rt_q[i] <= nvr_pkg::RT_RESET;
      end
    end
    else if (load_done)
    begin
      for (int i = 0; i < NR; i++)
        rt_q[i] <= nvm_q[i];
    end
    else if (wr_fire && in_range && !sel_n_s && vin_s && !en_s)
    begin
      nvm_q[idx] <= shreg_q;
      rt_q[idx] <= shreg_q;
    end
    else if (wr_fire && in_range && sel_n_s && (ptr_q <= nvr_pkg::RT_FREE_MAX || !en_s))
      rt_q[idx] <= shreg_q;
  end

  // Read source by select level
  always_comb
  begin
    rd_val = 8'h00;
    if (in_range && sel_n_s)
      rd_val = rt_q[idx];
    else if (in_range && !en_s)
      rd_val = nvm_q[idx];
  end

  // ==========================================================
  // Receive shift register
  always_ff @(posedge mclk)
  begin
    if (rst)
      shreg_q <= 8'h00;
    else if (scl_rise && bitcnt_q < 4'h8 && state_q != nvr_pkg::DS_IDLE)
      shreg_q <= {shreg_q[6:0], sda_s};
  end

  // Host acknowledge of read bytes
  always_ff @(posedge mclk)
  begin
    if (rst)
      mnack_q <= 1'b1;
    else if (scl_rise && bitcnt_q == 4'h8 && state_q == nvr_pkg::DS_RD)
      mnack_q <= sda_s;
  end

  // ==========================================================
  // Transaction sequencer, changes data only while clock is low
  always_ff @(posedge mclk)
  begin
    if (rst || loading_q)
    begin
      state_q <= nvr_pkg::DS_IDLE;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= nvr_pkg::DS_ADDR;
      bitcnt_q <= 4'hf; // Wraps to zero at the clock fall that ends the start
      sda_oe_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= nvr_pkg::DS_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (scl_fall && state_q != nvr_pkg::DS_IDLE)
    begin
      if (bitcnt_q == 4'h7)
      begin
        // Byte complete, enter acknowledge slot
        bitcnt_q <= 4'h8;
        unique case (state_q)
          nvr_pkg::DS_ADDR:
          begin
            if (shreg_q[7:1] == {nvr_pkg::DEV_ADDR_HI, strap_s})
            begin
              sda_oe_q <= 1'b1;
              rw_q <= shreg_q[0];
            end
            else
              state_q <= nvr_pkg::DS_IDLE;
          end
          nvr_pkg::DS_SUB:
          begin
            ptr_q <= shreg_q;
            sda_oe_q <= 1'b1;
          end
          nvr_pkg::DS_WR, nvr_pkg::DS_RD:
          begin
            ptr_q <= ptr_q + 8'h01;
            sda_oe_q <= (state_q == nvr_pkg::DS_WR); // Host acks read bytes itself
          end
          nvr_pkg::DS_IDLE: ;
        endcase
      end
      else if (bitcnt_q == 4'h8)
      begin
        // Acknowledge slot over, start next byte
        bitcnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        unique case (state_q)
          nvr_pkg::DS_ADDR:
          begin
            if (rw_q)
            begin
              state_q <= nvr_pkg::DS_RD;
              tx_q <= rd_val;
              sda_oe_q <= ~rd_val[7];
            end
            else
              state_q <= nvr_pkg::DS_SUB;
          end
          nvr_pkg::DS_SUB:
            state_q <= nvr_pkg::DS_WR;
          nvr_pkg::DS_RD:
          begin
            if (mnack_q)
              state_q <= nvr_pkg::DS_IDLE;
            else
            begin
              tx_q <= rd_val;
              sda_oe_q <= ~rd_val[7];
            end
          end
          nvr_pkg::DS_WR, nvr_pkg::DS_IDLE: ;
        endcase
      end
      else
      begin
        // Next bit; read data is shifted out MSB first
        bitcnt_q <= bitcnt_q + 4'h1;
        if (state_q == nvr_pkg::DS_RD)
        begin
          tx_q <= {tx_q[6:0], 1'b0};
          sda_oe_q <= ~tx_q[6];
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  assign bus.sda_d_o = 1'b0; // Open drain, only the enable moves
  assign bus.sda_d_oe = sda_oe_q;
  assign loading = loading_q;

  // Flattened run-time registers
  always_comb
  begin
    rt_regs = '0;
    for (int i = 0; i < NR; i++)
      rt_regs[i*8 +: 8] = rt_q[i];
  end
endmodule : nvr_dev

// File: rtl/nvr_host.sv
`timescale 1ns/10ps
module nvr_host #(
  parameter int NVM_GAP = nvr_pkg::NVM_GAP_CYCLES
) (
  // Bus side
  nvr_if.host bus,
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_nvm,
  input wire logic cmd_strap,
  input wire logic [7:0] cmd_sub,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // Response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  localparam int WMAX = (NVM_GAP > nvr_pkg::POR_CYCLES) ? NVM_GAP : nvr_pkg::POR_CYCLES;
  localparam int WW = $clog2(WMAX + 1);
  localparam int QW = $clog2(nvr_pkg::SCL_Q_CYCLES + 1);

  nvr_pkg::nvr_hst_t state_q;
  logic sda_s;
  logic [WW-1:0] wait_q;
  logic [QW-1:0] qcnt_q;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bitcnt_q;
  logic [1:0] bidx_q;
  logic rd_q;
  logic nvm_q;
  logic strap_q;
  logic [7:0] sub_q;
  logic [7:0] wd_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic recv;
  logic nack_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic sel_n_q;
  logic ready_q;
  logic rsp_valid_q;

  // ==========================================================
  // Data line synchronisation
  nvr_sync #(
    .W(1)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(bus.sda),
    .q(sda_s)
  );

  // Byte to send at each step of the sequence
  function automatic logic [7:0] byte_at(input logic [1:0] i);
    logic [7:0] b;
    b = {nvr_pkg::DEV_ADDR_HI, strap_q, 1'b0};
    if (i == 2'h1)
      b = sub_q;
    else if (i == 2'h2)
      b = rd_q ? {nvr_pkg::DEV_ADDR_HI, strap_q, 1'b1} : wd_q;
    return b;
  endfunction : byte_at

  assign recv = (bidx_q == 2'h3);

  // ==========================================================
  // Quarter-bit timer, keeps the clock under the maximum rate
  always_ff @(posedge mclk)
  begin
    if (rst || state_q == nvr_pkg::HS_IDLE || state_q == nvr_pkg::HS_WAIT || tick)
      qcnt_q <= '0;
    else
      qcnt_q <= qcnt_q + 1'b1;
  end

  assign tick = (qcnt_q == QW'(nvr_pkg::SCL_Q_CYCLES - 1));

  // ==========================================================
  // Bus sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= nvr_pkg::HS_WAIT;
      wait_q <= WW'(nvr_pkg::POR_CYCLES);
      ph_q <= 2'h0;
      bitcnt_q <= 4'h0;
      bidx_q <= 2'h0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sel_n_q <= 1'b1;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      nack_q <= 1'b0;
      rd_q <= 1'b0;
      nvm_q <= 1'b0;
      strap_q <= 1'b0;
      sub_q <= 8'h00;
      wd_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        nvr_pkg::HS_WAIT:
        begin
          if (wait_q == '0)
          begin
            state_q <= nvr_pkg::HS_IDLE;
            ready_q <= 1'b1;
          end
          else
            wait_q <= wait_q - 1'b1;
        end
        nvr_pkg::HS_IDLE:
        begin
          if (cmd_valid)
          begin
            // Start at once after driving the select
            ready_q <= 1'b0;
            rd_q <= cmd_read;
            nvm_q <= cmd_nvm;
            sel_n_q <= ~cmd_nvm;
            strap_q <= cmd_strap;
            sub_q <= cmd_sub;
            wd_q <= cmd_wdata;
            bidx_q <= 2'h0;
            nack_q <= 1'b0;
            ph_q <= 2'h0;
            state_q <= nvr_pkg::HS_START;
          end
        end
        nvr_pkg::HS_START:
        begin
          if (tick)
          begin
            // Data falls while clock is high
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              2'h3:
              begin
                scl_oe_q <= 1'b1;
                bitcnt_q <= 4'h0;
                tx_q <= byte_at(bidx_q);
                state_q <= nvr_pkg::HS_BYTE;
              end
            endcase
          end
        end
        nvr_pkg::HS_BYTE:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_oe_q <= (bitcnt_q < 4'h8 && !recv) ? ~tx_q[7] : 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2:
              begin
                if (bitcnt_q < 4'h8)
                begin
                  rx_q <= {rx_q[6:0], sda_s};
                  tx_q <= {tx_q[6:0], 1'b0};
                end
                else if (!recv)
                  nack_q <= sda_s;
              end
              2'h3:
              begin
                scl_oe_q <= 1'b1;
                bitcnt_q <= bitcnt_q + 4'h1;
                if (bitcnt_q == 4'h8)
                begin
                  // Byte done, choose next step
                  bitcnt_q <= 4'h0;
                  bidx_q <= bidx_q + 2'h1;
                  tx_q <= byte_at(bidx_q + 2'h1);
                  if (nack_q || bidx_q == 2'h3 || (bidx_q == 2'h2 && !rd_q))
                    state_q <= nvr_pkg::HS_STOP;
                  else if (bidx_q == 2'h1 && rd_q)
                    state_q <= nvr_pkg::HS_START;
                end
              end
            endcase
          end
        end
        nvr_pkg::HS_STOP:
        begin
          if (tick)
          begin
            // Data rises while clock is high
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              2'h3:
              begin
                rsp_valid_q <= 1'b1;
                sel_n_q <= 1'b1;
                if (nvm_q && !rd_q && !nack_q)
                begin
                  wait_q <= WW'(NVM_GAP);
                  state_q <= nvr_pkg::HS_WAIT;
                end
                else
                begin
                  ready_q <= 1'b1;
                  state_q <= nvr_pkg::HS_IDLE;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_q;
  assign bus.sda_h_o = 1'b0;
  assign bus.sda_h_oe = sda_oe_q;
  assign bus.storage_select_n = sel_n_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rx_q;
  assign rsp_nack = nack_q;
endmodule : nvr_host

// File: tb/nvr_properties.sv
`timescale 1ns/10ps
module nvr_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus signals
  input wire logic scl_oe,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic storage_select_n,
  input wire logic scl,
  input wire logic sda
);
  localparam int POR = nvr_pkg::POR_CYCLES;
  logic [11:0] por_q;

  // Cycles since reset release, saturating
  always_ff @(posedge mclk)
  begin
    if (rst)
      por_q <= 12'h000;
    else if (por_q != 12'hfff)
      por_q <= por_q + 12'h001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Link checks
  property p_host_quiet; por_q < POR |-> !scl_oe && !sda_h_oe; endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("host drove bus during load");
  property p_dev_quiet; por_q < POR |-> !sda_d_oe; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drove bus during load");
  property p_scl_low; $rose(scl_oe) |-> scl_oe [*8]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low phase too short");
  property p_scl_high; $fell(scl_oe) |-> !scl_oe [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
  property p_dev_edge; $changed(sda_d_oe) |-> !scl; endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved with clock high");
  property p_sel_idle; $changed(storage_select_n) |-> scl && sda; endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select moved in a transfer");
  property p_start_soon; $fell(storage_select_n) |-> ##[1:60] (scl && $fell(sda)); endproperty
  a_start_soon: assert property (p_start_soon) else $error("no start after select low");
  property p_start_quiet; scl && $fell(sda) |-> !sda_d_oe [*8]; endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("device drove after start");
  property p_stop_free; scl && $rose(sda) |-> !sda_d_oe && !scl_oe; endproperty
  a_stop_free: assert property (p_stop_free) else $error("bus held at stop");
endmodule : nvr_properties

// File: tb/nvr_tb.sv
`timescale 1ns/10ps
module nvr_tb;
  // ==========================================================
  // Signals
  localparam int GAP = 200;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic en = 1'b0;
  logic sup = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_nvm = 1'b0;
  logic cmd_strap = 1'b0;
  logic [7:0] cmd_sub = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, loading, scl_p, sda_p;
  logic [7:0] rsp_data, sh_q, byte_q;
  logic [3:0] bit_q;
  logic [87:0] rt_regs;
  logic [7:0] rt_m [11];
  logic [7:0] nv_m [11];
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #50 mclk = ~mclk;

  // ==========================================================
  // Both ends and checker
  nvr_if u_nvr_if ();
  nvr_dev u_nvr_dev (.bus(u_nvr_if.dev), .mclk(mclk), .rst(rst), .address_strap_pin(strap),
    .reg_enable(en), .supply_ge_8v(sup), .rt_regs(rt_regs), .loading(loading));
  nvr_host #(.NVM_GAP(GAP)) u_nvr_host (.bus(u_nvr_if.host), .mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_nvm(cmd_nvm), .cmd_strap(cmd_strap),
    .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  nvr_properties u_nvr_properties (.mclk(mclk), .rst(rst), .scl_oe(u_nvr_if.scl_oe),
    .sda_h_oe(u_nvr_if.sda_h_oe), .sda_d_oe(u_nvr_if.sda_d_oe), .scl(u_nvr_if.scl),
    .storage_select_n(u_nvr_if.storage_select_n), .sda(u_nvr_if.sda));

  // Last address byte seen on the wire, MSB first
  always @(posedge mclk)
  begin
    scl_p <= u_nvr_if.scl;
    sda_p <= u_nvr_if.sda;
    if (u_nvr_if.scl && scl_p && sda_p && !u_nvr_if.sda)
      bit_q <= 4'h0;
    else if (u_nvr_if.scl && !scl_p && bit_q < 4'h8)
    begin
      sh_q <= {sh_q[6:0], u_nvr_if.sda};
      bit_q <= bit_q + 4'h1;
      if (bit_q == 4'h7)
        byte_q <= {sh_q[6:0], u_nvr_if.sda};
    end
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [87:0] got, input logic [87:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [87:0] rt_pack();
    logic [87:0] v;
    for (int i = 0; i < 11; i++)
      v[8*i +: 8] = rt_m[i];
    return v;
  endfunction : rt_pack

  // Expected effect of an acked write
  function automatic void model_wr(input logic nvm, input logic [7:0] sub, input logic [7:0] d);
    if (sub < 8'h0b)
    begin
      if (nvm && sup && !en)
      begin
        nv_m[sub] = d;
        rt_m[sub] = d;
      end
      else if (!nvm && (sub <= nvr_pkg::RT_FREE_MAX || !en))
        rt_m[sub] = d;
    end
  endfunction : model_wr

  function automatic logic [7:0] model_rd(input logic nvm, input logic [7:0] sub);
    if (sub >= 8'h0b || (nvm && en))
      return 8'h00;
    return nvm ? nv_m[sub] : rt_m[sub];
  endfunction : model_rd

  // One transaction through the host, then checks
  task automatic do_op(input logic rd, nvm, e, s, a, ok, input logic [7:0] sub, d);
    int n;
    logic [7:0] exp;
    @(negedge mclk);
    en = e;
    sup = s;
    strap = a;
    repeat (4) @(negedge mclk);
    for (n = 0; cmd_ready !== 1'b1 && n < 3000; n++)
      @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_nvm = nvm;
    cmd_strap = ok ? a : ~a;
    cmd_sub = sub;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    exp = model_rd(nvm, sub);
    for (n = 0; rsp_valid !== 1'b1 && n < 3000; n++)
      @(negedge mclk);
    if (ok && !rd)
      model_wr(nvm, sub, d);
    chk(rsp_nack, !ok);
    chk(byte_q, {nvr_pkg::DEV_ADDR_HI, cmd_strap, rd && ok});
    if (ok && rd)
      chk(rsp_data, exp);
    chk(rt_regs, rt_pack());
    if (ok && nvm && !rd)
    begin
      for (n = 0; cmd_ready !== 1'b1 && n < 3000; n++)
        @(negedge mclk);
      chk(n >= GAP - 1, 1'b1);
    end
    $display("op rd=%0d nvm=%0d sub=%h done", rd, nvm, sub);
  endtask : do_op

  // ==========================================================
  // Main sequence
  initial
  begin
    int n;
    void'($urandom(32'hd366da8f));
    for (int i = 0; i < 11; i++)
    begin
      rt_m[i] = nvr_pkg::NVM_DEFAULT[8*i +: 8];
      nv_m[i] = nvr_pkg::NVM_DEFAULT[8*i +: 8];
    end
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    for (n = 0; loading === 1'b1 && n < 5000; n++)
      @(negedge mclk);
    chk(n >= nvr_pkg::POR_CYCLES - 1 && n <= nvr_pkg::POR_CYCLES + 1, 1'b1);
    chk(rt_regs, nvr_pkg::NVM_DEFAULT);
    $display("power-on load done");
    do_op(0, 0, 1, 1, 0, 1, 8'h02, 8'ha5);
    do_op(0, 0, 1, 1, 0, 1, 8'h03, 8'h5a);
    do_op(0, 1, 0, 1, 1, 1, 8'h03, 8'h3c);
    do_op(1, 1, 0, 1, 1, 1, 8'h03, 8'h00);
    do_op(0, 1, 0, 0, 0, 1, 8'h04, 8'h77);
    do_op(0, 1, 1, 1, 0, 1, 8'h05, 8'h11);
    do_op(1, 1, 1, 1, 0, 1, 8'h03, 8'h00);
    do_op(0, 0, 0, 1, 0, 1, 8'h0b, 8'hff);
    do_op(0, 0, 0, 1, 1, 0, 8'h00, 8'h99);
    do_op(1, 0, 1, 1, 0, 1, 8'h02, 8'h00);
    for (int i = 0; i < 25; i++)
      do_op(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
        $urandom_range(0, 7) != 0, 8'($urandom_range(0, 12)), 8'($urandom));
    end_sim();
  end
endmodule : nvr_tb
